// ---- src/timer16_params.svh ----
// register offsets, reset values and counting constants of the 16-bit timer core
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

// byte offsets on the apb bus, one aligned word each, byte data in bits 7:0
`define OFS_CTRL_A      8'h00
`define OFS_CTRL_B      8'h04
`define OFS_COUNT_LO    8'h08
`define OFS_COUNT_HI    8'h0c
`define OFS_CMP_A_LO    8'h10
`define OFS_CMP_A_HI    8'h14
`define OFS_CMP_B_LO    8'h18
`define OFS_CMP_B_HI    8'h1c
`define OFS_CAPT_LO     8'h20
`define OFS_CAPT_HI     8'h24
`define OFS_FLAGS       8'h28
`define OFS_MASK        8'h2c

// reset values: the power-off bit starts set, everything else clear
`define RST_CTRL_A      8'h80
`define RST_CTRL_B      8'h00
`define RST_WORD16      16'h0000
`define RST_FLAGS       4'h0

// count limits
`define COUNT_FLOOR     16'h0000
`define COUNT_MAX       16'hffff
`define TOP_FIX_8       16'h00ff
`define TOP_FIX_9       16'h01ff
`define TOP_FIX_10      16'h03ff

// prescaler width and the masks whose all-ones state marks a tick
`define PRESC_W         10
`define PRESC_M8        10'h007
`define PRESC_M64       10'h03f
`define PRESC_M256      10'h0ff
`define PRESC_M1024     10'h3ff

// noise filter length default, in clk samples
`define FILT_LEN_DEF    4

`endif

// ---- src/timer16_pkg.sv ----
// types shared by the 16-bit timer core
package timer16_pkg;

    // ceiling choice of the count sequence
    typedef enum logic [2:0] {
        TOP_MAX   = 3'h0,
        TOP_8     = 3'h1,
        TOP_9     = 3'h2,
        TOP_10    = 3'h3,
        TOP_CMP_A = 3'h4,
        TOP_CAPT  = 3'h5
    } top_sel_t;

    // timer tick source
    typedef enum logic [2:0] {
        CS_NONE     = 3'h0,
        CS_DIV1     = 3'h1,
        CS_DIV8     = 3'h2,
        CS_DIV64    = 3'h3,
        CS_DIV256   = 3'h4,
        CS_DIV1024  = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clk_sel_t;

    // control register a, msb first
    typedef struct packed {
        logic     power_off;  // timer_power_off_bit
        logic     cap_rise;   // capture on rising edge
        logic     cap_sel_b;  // use capture_input_b
        logic     retrig_en;  // retrigger_event enable
        logic     pwm_en;     // compare pins in pwm form
        top_sel_t top_sel;    // count ceiling
    } ctrl_a_t;

    // event flags, also the mask layout
    typedef struct packed {
        logic capture;
        logic compare_b;
        logic compare_a;
        logic overflow;
    } flags_t;

endpackage

// ---- src/timer16_core.sv ----
// 16-bit timer/counter core with byte-wide register access over apb
`timescale 1ns/10ps
`default_nettype none
`include "timer16_params.svh"

module timer16_core #(
    parameter int ADDR_W   = 8,                // apb address width
    parameter int FILT_LEN = `FILT_LEN_DEF     // noise filter samples
) (
    input  wire logic              clk,        // system clock, 100 mhz
    input  wire logic              srst,       // synchronous reset, high
    input  wire logic              psel,       // apb select
    input  wire logic              penable,    // apb access phase
    input  wire logic              pwrite,     // apb direction
    input  wire logic [ADDR_W-1:0] paddr,      // apb byte address
    input  wire logic [31:0]       pwdata,     // apb write data
    output logic      [31:0]       prdata,     // apb read data
    output logic                   pready,     // apb ready
    output logic                   pslverr,    // apb error, unmapped
    input  wire logic              external_count_pin, // external tick pin
    input  wire logic              capture_input_a,    // capture pin a
    input  wire logic              capture_input_b,    // capture pin b
    output logic      [1:0]        compare_output_pin, // b, a
    output logic                   irq                 // masked flag request
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (ADDR_W < 6 || FILT_LEN < 2 || FILT_LEN > 16)
    begin : g_bad_param
        $error("timer16_core: ADDR_W or FILT_LEN out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state

    timer16_pkg::ctrl_a_t     ctrl_a_q;          // timer_control_a
    timer16_pkg::clk_sel_t    clk_sel_q;         // timer_control_b
    logic [15:0]              count_value_q;     // count_value_reg
    logic [15:0]              capture_value_q;   // capture_value_reg
    logic [15:0]              cmp_sh_q  [2];     // compare_regs as written
    logic [15:0]              cmp_act_q [2];     // compare_regs in use
    logic [7:0]               hold_q;            // shared high-byte holding
    timer16_pkg::flags_t      flags_q;           // timer_flag_reg
    timer16_pkg::flags_t      mask_q;            // timer_mask_reg
    logic [`PRESC_W-1:0]      presc_q;           // prescaler
    logic                     ext_prev_q;        // last external pin level
    logic [1:0]               filt_q;            // filtered capture inputs
    logic                     cap_prev_q;        // last filtered selected input
    logic [31:0]              prdata_q;          // read data
    logic                     pready_q;          // answer
    logic                     pslverr_q;         // unmapped answer
    logic [1:0]               pin_q;             // compare pins
    logic                     irq_q;             // request

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    logic       rd_cap;       // read data latched, side effects happen here
    logic       wr_done;      // write takes effect here
    logic [7:0] addr8;        // low address byte
    logic       mapped;       // address hits a register
    logic [7:0] wbyte;        // written byte

    assign addr8   = paddr[7:0];
    assign wbyte   = pwdata[7:0];
    assign rd_cap  = psel && penable && !pready_q && !pwrite;
    // unmapped writes are dropped, so wide address buses cannot alias registers
    assign wr_done = psel && penable && pready_q && pwrite && mapped;
    assign mapped  = (addr8[1:0] == 2'h0) && (addr8 <= `OFS_MASK) && (paddr[ADDR_W-1:6] == '0);

    logic wr_cnt_lo;  // count low write
    logic wr_capt_lo; // capture low write, only when capture is the ceiling
    logic wr_hi;      // any high byte write
    assign wr_cnt_lo  = wr_done && addr8 == `OFS_COUNT_LO;
    assign wr_capt_lo = wr_done && addr8 == `OFS_CAPT_LO &&
                        ctrl_a_q.top_sel == timer16_pkg::TOP_CAPT;
    assign wr_hi      = wr_done && (addr8 == `OFS_COUNT_HI || addr8 == `OFS_CMP_A_HI ||
                                    addr8 == `OFS_CMP_B_HI || addr8 == `OFS_CAPT_HI);

    // read mux; high bytes of count and capture come from the holding register
    logic [7:0] rbyte;
    always_comb
    begin
        rbyte = 8'h00;
        case (addr8)
            `OFS_CTRL_A:   rbyte = ctrl_a_q;
            `OFS_CTRL_B:   rbyte = {5'h00, clk_sel_q};
            `OFS_COUNT_LO: rbyte = count_value_q[7:0];
            `OFS_COUNT_HI: rbyte = hold_q;
            `OFS_CMP_A_LO: rbyte = cmp_sh_q[0][7:0];
            `OFS_CMP_A_HI: rbyte = cmp_sh_q[0][15:8];
            `OFS_CMP_B_LO: rbyte = cmp_sh_q[1][7:0];
            `OFS_CMP_B_HI: rbyte = cmp_sh_q[1][15:8];
            `OFS_CAPT_LO:  rbyte = capture_value_q[7:0];
            `OFS_CAPT_HI:  rbyte = hold_q;
            `OFS_FLAGS:    rbyte = {4'h0, flags_q};
            `OFS_MASK:     rbyte = {4'h0, mask_q};
            default:       rbyte = 8'h00;
        endcase
    end

    // bus answer: one wait cycle, then pready with data or error
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (rd_cap)
                prdata_q <= {24'h00_0000, rbyte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers, plain bytes without ordering limits

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_a_q  <= timer16_pkg::ctrl_a_t'(`RST_CTRL_A);
            clk_sel_q <= timer16_pkg::CS_NONE;
            mask_q    <= timer16_pkg::flags_t'(`RST_FLAGS);
        end
        else if (wr_done)
        begin
            if (addr8 == `OFS_CTRL_A)
                ctrl_a_q <= timer16_pkg::ctrl_a_t'(wbyte);
            if (addr8 == `OFS_CTRL_B)
                clk_sel_q <= timer16_pkg::clk_sel_t'(wbyte[2:0]);
            if (addr8 == `OFS_MASK)
                mask_q <= timer16_pkg::flags_t'(wbyte[3:0]);
        end
    end

    // holding register: filled by any high write or by a low read of count/capture
    always_ff @(posedge clk)
    begin
        if (srst)
            hold_q <= 8'h00;
        else if (wr_hi)
            hold_q <= wbyte;
        else if (rd_cap && addr8 == `OFS_COUNT_LO)
            hold_q <= count_value_q[15:8];
        else if (rd_cap && addr8 == `OFS_CAPT_LO)
            hold_q <= capture_value_q[15:8];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock select and prescaler

    logic run;   // module powered and a source chosen
    logic tick;  // timer_tick
    assign run = !ctrl_a_q.power_off && clk_sel_q != timer16_pkg::CS_NONE;

    // prescaler held in reset while idle so the first divided tick is a full period
    always_ff @(posedge clk)
    begin
        if (srst || !run)
            presc_q <= '0;
        else
            presc_q <= presc_q + 1'b1;
    end

    // external pin is synchronous, so one register suffices for edge detection
    always_ff @(posedge clk)
    begin
        if (srst)
            ext_prev_q <= 1'b0;
        else
            ext_prev_q <= external_count_pin;
    end

    always_comb
    begin
        tick = 1'b0;
        unique case (clk_sel_q)
            timer16_pkg::CS_NONE:     tick = 1'b0;
            timer16_pkg::CS_DIV1:     tick = 1'b1;
            timer16_pkg::CS_DIV8:     tick = (presc_q & `PRESC_M8) == `PRESC_M8;
            timer16_pkg::CS_DIV64:    tick = (presc_q & `PRESC_M64) == `PRESC_M64;
            timer16_pkg::CS_DIV256:   tick = (presc_q & `PRESC_M256) == `PRESC_M256;
            timer16_pkg::CS_DIV1024:  tick = presc_q == `PRESC_M1024;
            timer16_pkg::CS_EXT_FALL: tick = ext_prev_q && !external_count_pin;
            timer16_pkg::CS_EXT_RISE: tick = !ext_prev_q && external_count_pin;
        endcase
        tick = tick && !ctrl_a_q.power_off;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capture inputs: noise filter per pin, then edge selection

    logic [1:0] cap_raw;
    assign cap_raw = {capture_input_b, capture_input_a};

    for (genvar i = 0; i < 2; i++)
    begin : g_filt
        logic [FILT_LEN-1:0] sh_q;  // recent samples
        // level only moves after FILT_LEN equal samples; costs one cycle more than that in delay
        always_ff @(posedge clk)
        begin
            if (srst)
            begin
                sh_q      <= '0;
                filt_q[i] <= 1'b0;
            end
            else
            begin
                sh_q <= {sh_q[FILT_LEN-2:0], cap_raw[i]};
                if (&sh_q)
                    filt_q[i] <= 1'b1;
                else if (~|sh_q)
                    filt_q[i] <= 1'b0;
            end
        end
    end

    logic cap_lvl;  // selected filtered input
    logic cap_evt;  // qualifying edge
    logic retrig;   // retrigger_event
    logic capt_en;  // capture allowed, not while capture is the ceiling
    assign cap_lvl = ctrl_a_q.cap_sel_b ? filt_q[1] : filt_q[0];
    assign cap_evt = !ctrl_a_q.power_off && (cap_lvl != cap_prev_q) && (cap_lvl == ctrl_a_q.cap_rise);
    assign retrig  = cap_evt && ctrl_a_q.retrig_en;
    assign capt_en = ctrl_a_q.top_sel != timer16_pkg::TOP_CAPT;

    always_ff @(posedge clk)
    begin
        if (srst)
            cap_prev_q <= 1'b0;
        else
            cap_prev_q <= cap_lvl;
    end

    // capture register: written by software only when it serves as the ceiling
    always_ff @(posedge clk)
    begin
        if (srst)
            capture_value_q <= `RST_WORD16;
        else if (wr_capt_lo)
            capture_value_q <= {hold_q, wbyte};
        else if (cap_evt && capt_en)
            capture_value_q <= count_value_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ceiling and counter

    logic [15:0] top_val;  // current ceiling
    logic        wrap;     // tick at the ceiling
    logic [15:0] count_nx; // count after this tick
    always_comb
    begin
        case (ctrl_a_q.top_sel)
            timer16_pkg::TOP_8:     top_val = `TOP_FIX_8;
            timer16_pkg::TOP_9:     top_val = `TOP_FIX_9;
            timer16_pkg::TOP_10:    top_val = `TOP_FIX_10;
            timer16_pkg::TOP_CMP_A: top_val = cmp_act_q[0];
            timer16_pkg::TOP_CAPT:  top_val = capture_value_q;
            default:                top_val = `COUNT_MAX;
        endcase
    end
    // a count above a lowered ceiling runs on to the maximum and wraps there
    assign wrap     = tick && (count_value_q == top_val || count_value_q == `COUNT_MAX);
    assign count_nx = wrap ? `COUNT_FLOOR : count_value_q + 16'h0001;

    always_ff @(posedge clk)
    begin
        if (srst)
            count_value_q <= `RST_WORD16;
        else if (wr_cnt_lo)
            count_value_q <= {hold_q, wbyte};
        else if (retrig)
            count_value_q <= `COUNT_FLOOR;
        else if (tick)
            count_value_q <= count_nx;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare channels

    logic [1:0] match;     // per-channel compare match on a tick
    logic       buffered;  // updates wait for the wrap
    logic       a_is_top;  // compare a defines the ceiling
    assign a_is_top = ctrl_a_q.top_sel == timer16_pkg::TOP_CMP_A;
    assign buffered = ctrl_a_q.pwm_en || a_is_top;

    for (genvar i = 0; i < 2; i++)
    begin : g_cmp
        logic [7:0] lo_ofs;
        assign lo_ofs   = (i == 0) ? `OFS_CMP_A_LO : `OFS_CMP_B_LO;
        assign match[i] = tick && count_value_q == cmp_act_q[i];

        // written copy and active copy; pwm modes and the compare a ceiling defer the change to the wrap
        always_ff @(posedge clk)
        begin
            if (srst)
            begin
                cmp_sh_q[i]  <= `RST_WORD16;
                cmp_act_q[i] <= `RST_WORD16;
            end
            else
            begin
                if (wr_done && addr8 == lo_ofs)
                    cmp_sh_q[i] <= {hold_q, wbyte};
                if (!buffered || wrap)
                    cmp_act_q[i] <= cmp_sh_q[i];
            end
        end

        // pwm: high while count is below compare, pin a held low while compare a is the ceiling; otherwise toggle on match
        always_ff @(posedge clk)
        begin
            if (srst)
                pin_q[i] <= 1'b0;
            else if (ctrl_a_q.pwm_en && i == 0 && a_is_top)
                pin_q[i] <= 1'b0;
            else if (ctrl_a_q.pwm_en && tick)
                pin_q[i] <= count_nx < cmp_act_q[i];
            else if (!ctrl_a_q.pwm_en && match[i])
                pin_q[i] <= !pin_q[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flags and request; a set in the clearing cycle wins

    timer16_pkg::flags_t set_f;
    timer16_pkg::flags_t clr_f;
    assign set_f = '{capture: cap_evt && capt_en, compare_b: match[1], compare_a: match[0], overflow: wrap};
    assign clr_f = (wr_done && addr8 == `OFS_FLAGS) ? timer16_pkg::flags_t'(wbyte[3:0])
                                                    : timer16_pkg::flags_t'(4'h0);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flags_q <= timer16_pkg::flags_t'(`RST_FLAGS);
            irq_q   <= 1'b0;
        end
        else
        begin
            flags_q <= (flags_q & ~clr_f) | set_f;
            irq_q   <= |(flags_q & mask_q);
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign compare_output_pin = pin_q;
    assign irq                = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_cnt_lo_write;
        psel && penable && pready && pwrite && addr8 == `OFS_COUNT_LO;
    endsequence

    sequence s_read_lo_capture;
        psel && penable && !pready && !pwrite && addr8 == `OFS_COUNT_LO;
    endsequence

    property p_power_freeze;
        @(posedge clk) disable iff (srst)
        ctrl_a_q.power_off && !wr_cnt_lo |=> count_value_q == $past(count_value_q);
    endproperty
    a_power_freeze: assert property (p_power_freeze) else $error("count moved while powered off");

    property p_no_source;
        @(posedge clk) disable iff (srst)
        clk_sel_q == timer16_pkg::CS_NONE && !wr_cnt_lo && !retrig |=> $stable(count_value_q);
    endproperty
    a_no_source: assert property (p_no_source) else $error("count moved with no source");

    property p_match_flag;
        @(posedge clk) disable iff (srst)
        tick && count_value_q == cmp_act_q[1] |=> flags_q.compare_b;
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("compare b match lost");

    property p_overflow;
        @(posedge clk) disable iff (srst)
        tick && !wr_cnt_lo && !retrig && count_value_q == top_val |=> count_value_q == 16'h0000 && flags_q.overflow;
    endproperty
    a_overflow: assert property (p_overflow) else $error("ceiling wrap wrong");

    property p_low_write;
        @(posedge clk) disable iff (srst)
        s_cnt_lo_write |=> count_value_q == {$past(hold_q), $past(pwdata[7:0])};
    endproperty
    a_low_write: assert property (p_low_write) else $error("16-bit write not joined");

    property p_low_read;
        @(posedge clk) disable iff (srst)
        s_read_lo_capture ##1 pready |-> hold_q == $past(count_value_q[15:8]) && prdata[7:0] == $past(count_value_q[7:0]);
    endproperty
    a_low_read: assert property (p_low_read) else $error("low read did not stage high byte");

    property p_cmp_bypass;
        @(posedge clk) disable iff (srst)
        psel && penable && !pwrite && (addr8 == `OFS_CMP_A_HI || addr8 == `OFS_CMP_B_LO) |=> $stable(hold_q);
    endproperty
    a_cmp_bypass: assert property (p_cmp_bypass) else $error("compare read touched holding");

    property p_capture;
        @(posedge clk) disable iff (srst)
        cap_evt && capt_en |=> capture_value_q == $past(count_value_q) && flags_q.capture;
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_buffered;
        @(posedge clk) disable iff (srst)
        buffered && !wrap |=> cmp_act_q[0] == $past(cmp_act_q[0]);
    endproperty
    a_buffered: assert property (p_buffered) else $error("compare changed off the update point");

    property p_write_wins;
        @(posedge clk) disable iff (srst)
        wr_cnt_lo && (tick || retrig) |=> count_value_q[7:0] == $past(pwdata[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("count write lost to counting");

endmodule // timer16_core
`default_nettype wire

// ---- testbench/host_cpu_model.sv ----
// apb host model standing in for the cpu on the timer core bus
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
    input  wire logic        clk,     // bus clock
    output logic             psel,    // select
    output logic             penable, // access phase
    output logic             pwrite,  // direction
    output logic [7:0]       paddr,   // byte address
    output logic [31:0]      pwdata,  // write data
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pready,  // ready
    input  wire logic        pslverr  // error
);
    // idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one byte transfer; request held until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        begin
            n = 0;
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= {24'h0, d};
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            // bounded wait, never trusts a fixed latency
            while (pready !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                n++;
            end
            ok = (n < 20);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule // host_cpu_model
`default_nettype wire

// ---- testbench/timer16_core_test.sv ----
// self-checking bench for the 16-bit timer core
`timescale 1ns/10ps
`default_nettype none
`include "timer16_params.svh"
module timer16_core_test;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, irq, err, ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] cmp_pins; // compare outputs, checked once after the compare a match
    int n_errors, tests_run, k;
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    timer16_core uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_pin(1'b0),
        .capture_input_a(1'b0), .capture_input_b(1'b0),
        .compare_output_pin(cmp_pins), .irq(irq));
    host_cpu_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bus access; a hung bus ends the run
    // single-threaded host, so no two-step access is ever split by an interrupt
    task automatic rw(input logic wr, input logic [7:0] a, input logic [7:0] d);
        host.xfer(wr, a, d, rd, err, ok);
        if (ok !== 1'b1)
        begin
            n_errors++;
            close_out();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_errors = 0;
        tests_run = 0;
        srst = 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rw(0, `OFS_CTRL_A, 8'h0);
        check(rd, {24'h0, `RST_CTRL_A});
        // clock selected but power-off still set: count must not move
        rw(1, `OFS_CTRL_B, 8'h01);
        rw(1, `OFS_COUNT_HI, 8'h01);
        rw(1, `OFS_COUNT_LO, 8'hff);
        repeat (5) @(posedge clk);
        rw(0, `OFS_COUNT_LO, 8'h0);
        check(rd, 32'hff);
        rw(0, `OFS_COUNT_HI, 8'h0);
        check(rd, 32'h01);
        // compare read must leave the holding byte alone
        rw(1, `OFS_CMP_B_HI, 8'h12);
        rw(1, `OFS_CMP_B_LO, 8'h34);
        rw(0, `OFS_COUNT_LO, 8'h0);
        rw(0, `OFS_CMP_B_HI, 8'h0);
        check(rd, 32'h12);
        rw(0, `OFS_COUNT_HI, 8'h0);
        check(rd, 32'h01);
        rw(0, 8'h30, 8'h0);
        check({31'h0, err}, 32'h1);
        // powered on with no clock source: idle
        rw(1, `OFS_CTRL_B, 8'h00);
        rw(1, `OFS_COUNT_HI, 8'h00);
        rw(1, `OFS_COUNT_LO, 8'h00);
        rw(1, `OFS_CMP_A_HI, 8'h00);
        rw(1, `OFS_CMP_A_LO, 8'h40);
        rw(1, `OFS_MASK, 8'h02);
        rw(1, `OFS_CTRL_A, 8'h00);
        repeat (8) @(posedge clk);
        rw(0, `OFS_COUNT_LO, 8'h0);
        check(rd, 32'h0);
        // undivided tick: compare a match raises its flag and irq
        rw(1, `OFS_CTRL_B, 8'h01);
        for (k = 0; k < 200 && irq !== 1'b1; k++)
            @(posedge clk);
        check({31'h0, irq}, 32'h1);
        check({30'h0, cmp_pins}, 32'h1);
        rw(0, `OFS_FLAGS, 8'h0);
        check(rd, 32'h02);
        // writing one clears the flag
        rw(1, `OFS_FLAGS, 8'h02);
        rw(0, `OFS_FLAGS, 8'h0);
        check(rd, 32'h00);
        // count write while ticking every cycle: the write wins, then counting goes on
        rw(1, `OFS_COUNT_HI, 8'h00);
        rw(1, `OFS_COUNT_LO, 8'h10);
        rw(0, `OFS_COUNT_LO, 8'h0);
        check(rd, 32'h12);
        // fixed ceiling 0x00ff: wrap sets overflow, high byte stays zero
        rw(1, `OFS_CTRL_A, 8'h01);
        repeat (300) @(posedge clk);
        rw(0, `OFS_FLAGS, 8'h0);
        check(rd & 32'h1, 32'h1);
        rw(0, `OFS_COUNT_LO, 8'h0);
        rw(0, `OFS_COUNT_HI, 8'h0);
        check(rd, 32'h0);
        close_out();
    end
endmodule // timer16_core_test
`default_nettype wire
